// File: dpm_monitor.sv
// Drive protection monitor: thermal current limit, clamp and supply supervision
`default_nettype none
// Overview of operation
// [RULE1] Cold motor: clamp to peak current
// [RULE2] Model temperatures; critical gives continuous limit
// [RULE3] Peak restored when no model critical
// [RULE4] Report temperature warning and limit in statusword
// [RULE5] Warning clamps limit to continuous current
// [RULE6] Ambient, resistance reduction, continuous current configurable
// [RULE7] Separate positive and negative set-point limits
// [RULE8] Fixed electronics supply thresholds
// [RULE9] Configurable motor supply lower threshold
// [RULE10] Motor upper threshold, capped at maximum
// [RULE11] Configurable out-of-range persistence delay
// [RULE12] Out-of-range at start blocks operation enable
// [RULE13] Status bit only after delay expires
// [RULE14] Power good while all voltages in range
// [RULE15] Electronics undervoltage: bit 19, stage off, latched
// [RULE16] Motor undervoltage: bit 20, stage off
// [RULE17] Zero motor threshold disables undervoltage check
// [RULE18] Overvoltage engages braking power reduction
// [RULE19] Brushless overvoltage adjusts rotor displacement angle
// [RULE20] Software should lower upper supply limit
// [RULE21] Bits 16 warning, 17 switch-off temperature
// [RULE22] Bit 18 on any supply overvoltage
// [RULE23] Delay counter restarts when voltage returns
// [RULE24] Evaluations run once per monitoring cycle
module dpm_monitor
  import dpm_pkg::*;
#(
  parameter int CYCLE_CLKS = DPM_CYCLE_CLKS,
  parameter int MODEL_SHIFT = 8
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // Configuration
  input wire dpm_thermal_cfg_type thermal_cfg_i,
  input wire dpm_supply_cfg_type supply_cfg_i,
  input wire logic [DPM_CUR_W-1:0] pos_limit_i,
  input wire logic [DPM_CUR_W-1:0] neg_limit_i,
  input wire logic brushless_i,
  // Measurements from outside the clock domain
  input wire logic [DPM_VOLT_W-1:0] elec_volt_i,
  input wire logic [DPM_VOLT_W-1:0] motor_volt_i,
  input wire logic [DPM_CUR_W-1:0] current_abs_i,
  input wire logic [DPM_TEMP_W-1:0] stage_ambient_i,
  // Drive state requests
  input wire logic enable_req_i,
  input wire logic fault_reset_i,
  input wire logic braking_i,
  // Current controller side
  input wire logic signed [DPM_CUR_W:0] setpoint_i,
  output logic signed [DPM_CUR_W:0] setpoint_o,
  output logic [DPM_CUR_W-1:0] current_limit_o,
  // Output stage and status
  output logic stage_enable_o,
  output logic op_enabled_o,
  output logic power_good_o,
  output logic ov_control_o,
  output logic angle_adjust_o,
  output logic [31:0] statusword_o
);
  initial begin
    if (CYCLE_CLKS < 2 || CYCLE_CLKS > 65535) $error("dpm_monitor: CYCLE_CLKS out of range");
  end

  typedef struct packed {
    logic [DPM_VOLT_W-1:0] ev1, ev2;
    logic [DPM_VOLT_W-1:0] mv1, mv2;
    logic [DPM_CUR_W-1:0] ci1, ci2;
    logic [DPM_TEMP_W-1:0] ta1, ta2;
    logic [15:0] div;
    logic tick;
    dpm_run_type run;
    logic limit_cont;
    logic signed [DPM_CUR_W:0] sp;
    logic [DPM_CUR_W-1:0] lim;
    dpm_status_type sts;
    logic pg;
    logic ovc;
    logic ang;
  } dpm_state_type;

  dpm_state_type st, next_st;
  logic [DPM_TEMP_W-1:0] motor_temp, stage_temp;
  logic elec_lo_raw, elec_hi_raw, mot_lo_raw, mot_hi_raw;
  logic elec_lo_f, elec_hi_f, mot_lo_f, mot_hi_f;
  logic [DPM_VOLT_W-1:0] mot_high_eff;
  logic hot_crit, hot_warn, hot_off, any_out;
  logic signed [DPM_CUR_W:0] pos_lim_s, neg_lim_s;

  function automatic logic above(input logic [15:0] val, input logic [15:0] thr);
    return val > thr;
  endfunction

  dpm_thermal #(.SHIFT(MODEL_SHIFT)) u_motor_model ( // [RULE2] [RULE6]
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .tick_i(st.tick),
    .current_i(st.ci2),
    .ambient_i(thermal_cfg_i.ambient),
    .rth_reduction_i(thermal_cfg_i.rth_reduction),
    .temp_o(motor_temp)
  );

  dpm_thermal #(.SHIFT(MODEL_SHIFT)) u_stage_model ( // [RULE2]
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .tick_i(st.tick),
    .current_i(st.ci2),
    .ambient_i(st.ta2),
    .rth_reduction_i(8'h00),
    .temp_o(stage_temp)
  );

  // Upper motor threshold may be raised only up to the permitted maximum
  assign mot_high_eff = (supply_cfg_i.motor_high > DPM_MOT_MAX_MV) ? DPM_MOT_MAX_MV
    : supply_cfg_i.motor_high; // [RULE10]
  assign elec_lo_raw = st.ev2 < DPM_ELEC_MIN_MV; // [RULE8]
  assign elec_hi_raw = above(st.ev2, DPM_ELEC_MAX_MV); // [RULE8]
  assign mot_lo_raw = (supply_cfg_i.motor_low != '0) && (st.mv2 < supply_cfg_i.motor_low); // [RULE9] [RULE17]
  assign mot_hi_raw = above(st.mv2, mot_high_eff);
  assign any_out = elec_lo_raw | elec_hi_raw | mot_lo_raw | mot_hi_raw;

  // One persistence checker per supply condition
  dpm_supply_check u_elec_lo (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .tick_i(st.tick),
    .out_i(elec_lo_raw), .delay_i(supply_cfg_i.delay_cycles), .fault_o(elec_lo_f)
  );
  dpm_supply_check u_elec_hi (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .tick_i(st.tick),
    .out_i(elec_hi_raw), .delay_i(supply_cfg_i.delay_cycles), .fault_o(elec_hi_f)
  );
  dpm_supply_check u_mot_lo (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .tick_i(st.tick),
    .out_i(mot_lo_raw), .delay_i(supply_cfg_i.delay_cycles), .fault_o(mot_lo_f)
  ); // [RULE11] [RULE13] [RULE23]
  dpm_supply_check u_mot_hi (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .tick_i(st.tick),
    .out_i(mot_hi_raw), .delay_i(supply_cfg_i.delay_cycles), .fault_o(mot_hi_f)
  );

  assign hot_warn = above(motor_temp, thermal_cfg_i.warn_temp) | above(stage_temp, thermal_cfg_i.warn_temp);
  assign hot_off = above(motor_temp, thermal_cfg_i.off_temp) | above(stage_temp, thermal_cfg_i.off_temp);
  // Critical model temperature is the warning threshold
  assign hot_crit = hot_warn;
  assign pos_lim_s = $signed({1'b0, pos_limit_i});
  assign neg_lim_s = -$signed({1'b0, neg_limit_i});

  always_comb begin
    logic [DPM_CUR_W-1:0] lim_pos, lim_neg;
    lim_pos = '0;
    lim_neg = '0;
    next_st = st;
    next_st.ev1 = elec_volt_i;
    next_st.ev2 = st.ev1;
    next_st.mv1 = motor_volt_i;
    next_st.mv2 = st.mv1;
    next_st.ci1 = current_abs_i;
    next_st.ci2 = st.ci1;
    // Stage sensor reading crosses in like the supply measurements
    next_st.ta1 = stage_ambient_i;
    next_st.ta2 = st.ta1;
    next_st.tick = 1'b0;
    if (st.div == 16'(CYCLE_CLKS - 1)) begin // [RULE24]
      next_st.div = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.div = st.div + 16'h0001;
    end
    if (st.tick) begin
      next_st.limit_cont = hot_crit; // [RULE2] [RULE3] [RULE5]
      next_st.sts.warn = hot_warn; // [RULE4] [RULE21]
      next_st.sts.off = hot_off; // [RULE4] [RULE21]
      next_st.sts.over = elec_hi_f | mot_hi_f; // [RULE22]
      next_st.sts.motor_low = mot_lo_f; // [RULE16]
      next_st.sts.elec_low = st.sts.elec_low | elec_lo_f; // [RULE15]
      if (fault_reset_i && !elec_lo_f) begin
        next_st.sts.elec_low = 1'b0;
      end
      next_st.pg = !(elec_lo_f | elec_hi_f | mot_lo_f | mot_hi_f); // [RULE14]
      next_st.ovc = braking_i & mot_hi_raw; // [RULE18]
      next_st.ang = braking_i & mot_hi_raw & brushless_i; // [RULE19]
    end
    // Active limit: peak when cool, continuous when critical
    next_st.lim = st.limit_cont ? thermal_cfg_i.cont_current : thermal_cfg_i.peak_current; // [RULE1] [RULE5]
    lim_pos = (pos_limit_i < st.lim) ? pos_limit_i : st.lim;
    lim_neg = (neg_limit_i < st.lim) ? neg_limit_i : st.lim;
    if (setpoint_i > $signed({1'b0, lim_pos})) begin // [RULE7]
      next_st.sp = $signed({1'b0, lim_pos});
    end else if (setpoint_i < -$signed({1'b0, lim_neg})) begin // [RULE7]
      next_st.sp = -$signed({1'b0, lim_neg});
    end else begin
      next_st.sp = setpoint_i;
    end
    case (st.run)
      DPM_RUN_IDLE: begin
        if (enable_req_i && !any_out && !st.sts.elec_low) begin // [RULE12]
          next_st.run = DPM_RUN_ENABLED;
        end
      end
      DPM_RUN_ENABLED: begin
        if (!enable_req_i) begin
          next_st.run = DPM_RUN_IDLE;
        end
        if (elec_lo_f || mot_lo_f) begin // [RULE15] [RULE16]
          next_st.run = DPM_RUN_TRIPPED;
        end
      end
      DPM_RUN_TRIPPED: begin
        // No automatic restart: needs fault reset and a dropped request
        if (fault_reset_i && !enable_req_i && !elec_lo_f && !mot_lo_f) begin
          next_st.run = DPM_RUN_IDLE;
        end
      end
      default: begin
        next_st.run = DPM_RUN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  assign setpoint_o = st.sp;
  assign current_limit_o = st.lim;
  assign op_enabled_o = st.run == DPM_RUN_ENABLED;
  // Stage drops in the same cycle an undervoltage fault flag rises
  assign stage_enable_o = op_enabled_o && !elec_lo_f && !mot_lo_f; // [RULE15] [RULE16]
  assign power_good_o = st.pg;
  assign ov_control_o = st.ovc;
  assign angle_adjust_o = st.ang;
  always_comb begin
    statusword_o = 32'h0000_0000;
    statusword_o[DPM_SW_TWARN] = st.sts.warn;
    statusword_o[DPM_SW_TOFF] = st.sts.off;
    statusword_o[DPM_SW_OVER] = st.sts.over;
    statusword_o[DPM_SW_ELOW] = st.sts.elec_low;
    statusword_o[DPM_SW_MLOW] = st.sts.motor_low;
  end

  // Assertions
  // Supply supervision
  stage_off_fault_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE16]
    (elec_lo_f || mot_lo_f) |-> !stage_enable_o)
    else $error("stage on during undervoltage");
  elec_latch_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE15]
    (st.sts.elec_low && !fault_reset_i && clk_en_i) |=> st.sts.elec_low)
    else $error("elec low lost");
  trip_entry_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE15]
    (st.run == DPM_RUN_ENABLED && clk_en_i && (elec_lo_f || mot_lo_f)) |=> st.run == DPM_RUN_TRIPPED)
    else $error("undervoltage did not trip");
  enable_gate_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE12]
    (st.run == DPM_RUN_IDLE && any_out && clk_en_i) |=> st.run != DPM_RUN_ENABLED)
    else $error("enabled while out of range");
  pg_status_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE14]
    (st.sts.motor_low || st.sts.over) |-> !st.pg)
    else $error("power good with fault");
  zero_thr_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE17]
    (supply_cfg_i.motor_low == '0) |-> !mot_lo_raw)
    else $error("zero threshold still monitors");
  ovc_brake_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE18]
    (st.tick && clk_en_i && !braking_i) |=> !ov_control_o)
    else $error("ov control without braking");
  angle_ov_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE19]
    angle_adjust_o |-> ov_control_o)
    else $error("angle adjust without ov control");
  tick_period_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE24]
    (st.tick && clk_en_i) |=> !st.tick)
    else $error("tick too frequent");
  // Set-point clamp and thermal limit
  pos_clamp_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE7]
    st.sp <= pos_lim_s || $changed(pos_limit_i) || $past(sys_rst_i))
    else $error("positive clamp exceeded");
  neg_clamp_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE7]
    st.sp >= neg_lim_s || $changed(neg_limit_i) || $past(sys_rst_i))
    else $error("negative clamp exceeded");
  cont_limit_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE5]
    (st.limit_cont && clk_en_i && $stable(thermal_cfg_i)) |=> st.lim == $past(thermal_cfg_i.cont_current))
    else $error("continuous limit not applied");
  peak_limit_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE1]
    (!st.limit_cont && clk_en_i && $stable(thermal_cfg_i)) |=> st.lim == $past(thermal_cfg_i.peak_current))
    else $error("peak limit not applied");
  warn_cont_a: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [RULE5]
    (st.tick && clk_en_i && hot_warn) |=> st.limit_cont)
    else $error("warning did not select continuous limit");

  // Main scenarios
  trip_c: cover property (@(posedge clock_i) st.run == DPM_RUN_TRIPPED);
  thermal_c: cover property (@(posedge clock_i) st.limit_cont);
  ovc_c: cover property (@(posedge clock_i) ov_control_o);
  elec_latch_c: cover property (@(posedge clock_i) st.sts.elec_low);
  refuse_c: cover property (@(posedge clock_i) st.run == DPM_RUN_IDLE && enable_req_i && any_out);
endmodule : dpm_monitor
`default_nettype wire

// File: dpm_pkg.sv
// Package: constants and carrier types of the drive protection monitor
`default_nettype none
package dpm_pkg;
  localparam int DPM_CUR_W = 16;
  localparam int DPM_TEMP_W = 16;
  localparam int DPM_VOLT_W = 16;
  localparam int DPM_DLY_W = 16;
  localparam int DPM_CLK_HZ = 40_000_000;
  // Monitoring cycle in microseconds and its length in clock cycles
  localparam int DPM_CYCLE_US = 100;
  localparam int DPM_CYCLE_CLKS = DPM_CYCLE_US * (DPM_CLK_HZ / 1_000_000);
  // Fixed electronics supply thresholds (mV)
  localparam logic [15:0] DPM_ELEC_MIN_MV = 16'h2EE0;
  localparam logic [15:0] DPM_ELEC_MAX_MV = 16'hC350;
  // Maximum permitted motor supply upper threshold (mV)
  localparam logic [15:0] DPM_MOT_MAX_MV = 16'hC350;
  // Device statusword bit positions
  localparam int DPM_SW_TWARN = 16;
  localparam int DPM_SW_TOFF = 17;
  localparam int DPM_SW_OVER = 18;
  localparam int DPM_SW_ELOW = 19;
  localparam int DPM_SW_MLOW = 20;
  localparam logic [DPM_TEMP_W-1:0] DPM_TEMP_RST = 16'h0000;

  typedef struct packed {
    logic [DPM_TEMP_W-1:0] ambient;
    logic [7:0] rth_reduction;
    logic [DPM_CUR_W-1:0] cont_current;
    logic [DPM_CUR_W-1:0] peak_current;
    logic [DPM_TEMP_W-1:0] warn_temp;
    logic [DPM_TEMP_W-1:0] off_temp;
  } dpm_thermal_cfg_type;

  typedef struct packed {
    logic [DPM_VOLT_W-1:0] motor_low;
    logic [DPM_VOLT_W-1:0] motor_high;
    logic [DPM_DLY_W-1:0] delay_cycles;
  } dpm_supply_cfg_type;

  typedef struct packed {
    logic warn;
    logic off;
    logic over;
    logic elec_low;
    logic motor_low;
  } dpm_status_type;

  typedef enum logic [1:0] {
    DPM_RUN_IDLE = 2'b00,
    DPM_RUN_ENABLED = 2'b01,
    DPM_RUN_TRIPPED = 2'b10
  } dpm_run_type;
endpackage : dpm_pkg
`default_nettype wire

// File: dpm_supply_check.sv
// Supply range check with persistence delay counted in monitoring cycles
`default_nettype none
module dpm_supply_check
  import dpm_pkg::*;
(
  // Clock and control
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic tick_i,
  // Condition and delay
  input wire logic out_i,
  input wire logic [DPM_DLY_W-1:0] delay_i,
  // Result
  output logic fault_o
);
  typedef struct packed {
    logic [DPM_DLY_W:0] cnt;
    logic fault;
  } dpm_sc_state_type;

  dpm_sc_state_type st, next_st;

  always_comb begin
    next_st = st;
    if (tick_i) begin
      if (!out_i) begin
        next_st.cnt = '0;
        next_st.fault = 1'b0;
      end else if (st.cnt > {1'b0, delay_i}) begin
        next_st.fault = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  assign fault_o = st.fault;
endmodule : dpm_supply_check
`default_nettype wire

// File: dpm_supply_model.sv
// Partner model: supply measurements and output stage current
`default_nettype none
module dpm_supply_model
  import dpm_pkg::*;
(
  // Clock and stage state
  input wire logic clock_i,
  input wire logic stage_enable_i,
  input wire logic braking_i,
  input wire logic ov_control_i,
  // Commanded levels
  input wire logic [DPM_VOLT_W-1:0] elec_cmd_i,
  input wire logic [DPM_VOLT_W-1:0] motor_cmd_i,
  input wire logic [DPM_CUR_W-1:0] load_cmd_i,
  // Measurements
  output logic [DPM_VOLT_W-1:0] elec_volt_o,
  output logic [DPM_VOLT_W-1:0] motor_volt_o,
  output logic [DPM_CUR_W-1:0] current_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Converters run unrelated to the monitor, so values move between edges
  always @(posedge clock_i) begin
    #3;
    elec_volt_o = elec_cmd_i;
    // Regeneration lifts the bus until overvoltage control acts
    motor_volt_o = motor_cmd_i + ((braking_i && !ov_control_i) ? 16'h0100 : 16'h0000);
    // No current flows while the stage is off
    current_o = stage_enable_i ? load_cmd_i : 16'h0000;
  end
endmodule // dpm_supply_model
`default_nettype wire

// File: dpm_thermal.sv
// Thermal model of one heated part: first-order rise from squared current
`default_nettype none
module dpm_thermal
  import dpm_pkg::*;
#(
  parameter int SHIFT = 8
) (
  // Clock and control
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic tick_i,
  // Model inputs
  input wire logic [DPM_CUR_W-1:0] current_i,
  input wire logic [DPM_TEMP_W-1:0] ambient_i,
  input wire logic [7:0] rth_reduction_i,
  // Model output
  output logic [DPM_TEMP_W-1:0] temp_o
);
  initial begin
    if (SHIFT < 1 || SHIFT > 15) $error("dpm_thermal: SHIFT out of range");
  end

  typedef struct packed {
    logic [DPM_TEMP_W-1:0] temp;
  } dpm_th_state_type;

  dpm_th_state_type st, next_st;
  logic [31:0] sq;
  logic [31:0] heat;
  logic signed [33:0] delta;
  logic signed [33:0] sum;

  always_comb begin
    next_st = st;
    sq = 32'(current_i) * 32'(current_i);
    // Reduced thermal resistance scales the steady rise down
    heat = (sq >> 16) - ((sq >> 16) * 32'(rth_reduction_i) >> 8);
    delta = $signed({2'b00, heat}) + $signed({18'h0_0000, ambient_i})
      - $signed({18'h0_0000, st.temp});
    sum = $signed({18'h0_0000, st.temp}) + (delta >>> SHIFT);
    if (tick_i) begin
      // Saturate so a hot part never wraps round to a cold reading
      if (sum[33]) begin
        next_st.temp = '0;
      end else if (sum[32:16] != 17'h0_0000) begin
        next_st.temp = '1;
      end else begin
        next_st.temp = sum[DPM_TEMP_W-1:0];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st <= '{temp: DPM_TEMP_RST};
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  assign temp_o = st.temp;
endmodule : dpm_thermal
`default_nettype wire

// File: test_dpm_monitor.sv
// Testbench of the drive protection monitor with queued expectations
`default_nettype none
module test_dpm_monitor
  import dpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  localparam int D = 5;
  typedef struct {int sel; logic [31:0] val; string nm;} dpm_note_type;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en = 1'b1;
  dpm_thermal_cfg_type tcfg;
  dpm_supply_cfg_type scfg;
  logic [DPM_CUR_W-1:0] pos_lim, neg_lim, i_cmd, cur, lim_o;
  logic [DPM_VOLT_W-1:0] e_cmd, m_cmd, e_v, m_v;
  logic en_req, f_rst, brake, bless, stage_en, op_en, pgood, ovc, angle;
  logic signed [DPM_CUR_W:0] sp_in, sp_out, exp_sp, plim, nlim;
  logic [31:0] sw;
  logic [31:0] lfsr = 32'h0001_0C2D;
  dpm_note_type exp_q[$];
  dpm_note_type note;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;

  always #12.5 clock_i = ~clock_i;

  dpm_monitor #(.CYCLE_CLKS(TK), .MODEL_SHIFT(8)) uut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en),
    .thermal_cfg_i(tcfg), .supply_cfg_i(scfg), .pos_limit_i(pos_lim), .neg_limit_i(neg_lim),
    .brushless_i(bless), .elec_volt_i(e_v), .motor_volt_i(m_v), .current_abs_i(cur),
    .stage_ambient_i(16'h0000), .enable_req_i(en_req), .fault_reset_i(f_rst), .braking_i(brake),
    .setpoint_i(sp_in), .setpoint_o(sp_out), .current_limit_o(lim_o), .stage_enable_o(stage_en),
    .op_enabled_o(op_en), .power_good_o(pgood), .ov_control_o(ovc), .angle_adjust_o(angle),
    .statusword_o(sw));

  dpm_supply_model model (
    .clock_i(clock_i), .stage_enable_i(stage_en), .braking_i(brake), .ov_control_i(ovc),
    .elec_cmd_i(e_cmd), .motor_cmd_i(m_cmd), .load_cmd_i(i_cmd),
    .elec_volt_o(e_v), .motor_volt_o(m_v), .current_o(cur));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] bit_of(input int b);
    return 32'h0000_0001 << b;
  endfunction

  function automatic logic [31:0] out_of(input int sel);
    logic [4:0] flags;
    flags = {angle, ovc, pgood, op_en, stage_en};
    if (sel == 0) return sw;
    if (sel == 1) return 32'(sp_out);
    if (sel == 2) return 32'(lim_o);
    return 32'(flags[sel-3]);
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask

  task automatic expect_out(input int sel, input logic [31:0] v, input string nm);
    exp_q.push_back('{sel, v, nm});
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compare just after the falling edge, while the registered outputs stand
  always @(negedge clock_i) begin
    #1;
    while (exp_q.size() != 0) begin
      note = exp_q.pop_front();
      check(note.nm, out_of(note.sel), note.val);
    end
  end

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    tcfg = '{16'h0000, 8'h00, 16'h0800, 16'h1000, 16'h0400, 16'h0800};
    scfg = '{16'h4650, 16'h7530, 16'(D)};
    pos_lim = 16'h0300;
    neg_lim = 16'h0200;
    i_cmd = 16'h0000;
    e_cmd = 16'h5DC0;
    m_cmd = 16'h5DC0;
    en_req = 1'b0;
    f_rst = 1'b0;
    brake = 1'b0;
    bless = 1'b1;
    sp_in = '0;
    idle(12);
    sys_rst_i = 1'b0;
    idle(3 * TK);
    expect_out(5, 1, "power_good");
    expect_out(0, 0, "statusword");
    expect_out(2, 32'(tcfg.peak_current), "current_limit");
    plim = $signed({1'b0, pos_lim});
    nlim = -$signed({1'b0, neg_lim});
    for (int i = 0; i < 12; i++) begin
      lfsr = next_rand(lfsr);
      sp_in = (i == 0) ? plim + 17'sh0_0001 : (i == 1) ? nlim - 17'sh0_0001 : $signed(lfsr[16:0]);
      exp_sp = (sp_in > plim) ? plim : (sp_in < nlim) ? nlim : sp_in;
      idle(1);
      expect_out(1, 32'(exp_sp), "setpoint");
    end
    en_req = 1'b1;
    idle(2 * TK);
    expect_out(4, 1, "op_enabled");
    expect_out(3, 1, "stage_enable");
    // Heavy load heats both models past warning and switch-off levels
    i_cmd = 16'hFFFF;
    idle(60 * TK);
    expect_out(2, 32'(tcfg.cont_current), "current_limit");
    expect_out(0, bit_of(DPM_SW_TWARN) | bit_of(DPM_SW_TOFF), "statusword");
    tcfg.warn_temp = 16'hF000;
    tcfg.off_temp = 16'hF000;
    i_cmd = 16'h0000;
    idle(4 * TK);
    expect_out(2, 32'(tcfg.peak_current), "current_limit");
    expect_out(0, 0, "statusword");
    tcfg.warn_temp = 16'h0400;
    idle(3 * TK);
    expect_out(2, 32'(tcfg.cont_current), "current_limit");
    tcfg.warn_temp = 16'hF000;
    // Short dip, recovery, second dip: the persistence count must restart
    m_cmd = 16'h2710;
    idle(4 * TK);
    m_cmd = 16'h5DC0;
    idle(3 * TK);
    m_cmd = 16'h2710;
    idle(5 * TK);
    expect_out(0, 0, "statusword");
    expect_out(3, 1, "stage_enable");
    idle((D + 4) * TK);
    expect_out(0, bit_of(DPM_SW_MLOW), "statusword");
    expect_out(3, 0, "stage_enable");
    expect_out(4, 0, "op_enabled");
    expect_out(5, 0, "power_good");
    m_cmd = 16'h5DC0;
    en_req = 1'b0;
    f_rst = 1'b1;
    idle(3 * TK);
    f_rst = 1'b0;
    scfg.motor_low = 16'h0000;
    m_cmd = 16'h0000;
    idle((D + 4) * TK);
    expect_out(0, 0, "statusword");
    expect_out(5, 1, "power_good");
    // Upper threshold asked above the cap still trips at the maximum
    scfg = '{16'h4650, 16'hFFFF, 16'(D)};
    m_cmd = 16'hC738;
    en_req = 1'b1;
    idle(2 * TK);
    expect_out(4, 0, "op_enabled");
    expect_out(0, 0, "statusword");
    idle((D + 4) * TK);
    expect_out(0, bit_of(DPM_SW_OVER), "statusword");
    expect_out(5, 0, "power_good");
    brake = 1'b1;
    idle(2 * TK);
    expect_out(6, 1, "ov_control");
    expect_out(7, 1, "angle_adjust");
    bless = 1'b0;
    idle(2 * TK);
    expect_out(7, 0, "angle_adjust");
    expect_out(6, 1, "ov_control");
    brake = 1'b0;
    bless = 1'b1;
    idle(2 * TK);
    expect_out(6, 0, "ov_control");
    scfg.motor_high = 16'h7530;
    m_cmd = 16'h5DC0;
    idle((D + 4) * TK);
    expect_out(4, 1, "op_enabled");
    expect_out(0, 0, "statusword");
    // Electronics undervoltage latches until a fault reset
    e_cmd = 16'h2710;
    idle((D + 4) * TK);
    expect_out(0, bit_of(DPM_SW_ELOW), "statusword");
    expect_out(3, 0, "stage_enable");
    e_cmd = 16'h5DC0;
    idle((D + 4) * TK);
    expect_out(0, bit_of(DPM_SW_ELOW), "statusword");
    expect_out(4, 0, "op_enabled");
    en_req = 1'b0;
    f_rst = 1'b1;
    idle(2 * TK);
    f_rst = 1'b0;
    idle(2 * TK);
    expect_out(0, 0, "statusword");
    // A low clock enable freezes supervision even through a long dip
    clk_en = 1'b0;
    e_cmd = 16'h2710;
    idle((D + 4) * TK);
    expect_out(0, 0, "statusword");
    expect_out(5, 1, "power_good");
    e_cmd = 16'h5DC0;
    idle(2);
    clk_en = 1'b1;
    idle(2);
    tally_and_finish();
  end
endmodule // test_dpm_monitor
`default_nettype wire
